// file: hw/tcc_pin_ctrl.sv
// type-c configuration channel pin controller: strap modes, shared status pins, interrupt
// assumes attach detection, bus engine and analog terminations live outside, all on CLK_SYS
`timescale 1ns/1ps
`include "tcc_consts.svh"
module tcc_pin_ctrl
	import tcc_pkg::*;
(
	input  wire logic       CLK_SYS,
	input  wire logic       RST_B,
	input  wire logic [1:0] ROLE_STRAP,
	input  wire logic [1:0] CTRL_STRAP,
	input  wire logic       GLOBAL_ENABLE_N,
	input  wire logic       ATTACHED,
	input  wire logic       ATTACH_AS_SRC,
	input  wire logic       AUDIO_ACC,
	input  wire logic [1:0] ATTACH_CURRENT,
	input  wire logic       DRP_SEEK_SRC,
	input  wire logic       HOST_STATUS_READ,
	input  wire logic       I2C_SDA_PULL,
	input  wire logic       I2C_SCL_PULL,
	input  wire logic       CURRENT_MODE_BIT_LO_I,
	input  wire logic       CURRENT_MODE_BIT_HI_I,
	output logic            CURRENT_MODE_BIT_LO_O,
	output logic            CURRENT_MODE_BIT_LO_OE,
	output logic            CURRENT_MODE_BIT_HI_O,
	output logic            CURRENT_MODE_BIT_HI_OE,
	output logic            IRQ_FLAG_N_O,
	output logic            IRQ_FLAG_N_OE,
	output logic            SOURCE_ROLE_FLAG_N_O,
	output logic            SOURCE_ROLE_FLAG_N_OE,
	output logic            CONFIG_CHANNEL_A_PULLUP,
	output logic            CONFIG_CHANNEL_B_PULLUP,
	output logic            I2C_MODE,
	output logic [6:0]      I2C_ADDR,
	output logic            BUS_SDA,
	output logic            BUS_SCL,
	output logic            BUS_RATE_ERR,
	output logic            POWER_SAVE,
	output logic            STATUS_PENDING
);

	localparam logic [5:0] SCL_LOW_LIM  = 6'(`TCC_SCL_LOW_MIN_CYC - 1);
	localparam logic [5:0] SCL_HIGH_LIM = 6'(`TCC_SCL_HIGH_MIN_CYC - 1);

	tcc_strap_if  strap ();
	tcc_state_t   st;
	tcc_state_t   next_st;
	tcc_status_t  stat_q;
	tcc_status_t  stat_prev;
	logic         stat_change;
	logic         active;
	logic         scl_prev;
	logic         scl_seen;
	logic [5:0]   scl_cnt;

	function automatic logic [1:0] cur_pins(input logic att, input logic [1:0] cur);
		if (!att)
			cur_pins = `TCC_PINS_NONE;
		else if (cur == `TCC_CUR_3P0)
			cur_pins = `TCC_PINS_3P0;
		else if (cur == `TCC_CUR_1P5)
			cur_pins = `TCC_PINS_1P5;
		else
			cur_pins = `TCC_PINS_DEFAULT;
	endfunction

	tcc_strap_latch u_strap (
		.clk_sys    (CLK_SYS),
		.rst_b      (RST_B),
		.role_strap (ROLE_STRAP),
		.ctrl_strap (CTRL_STRAP),
		.strap      (strap.src)
	);

	// mode selection; boot holds until the straps are caught
	always_comb
	begin
		next_st = st;
		unique case (st)
			ST_BOOT:
				if (strap.valid)
					next_st = GLOBAL_ENABLE_N ? ST_SAVE : (strap.i2c_sel ? ST_I2C : ST_PIN);
			ST_SAVE:
				if (!GLOBAL_ENABLE_N)
					next_st = strap.i2c_sel ? ST_I2C : ST_PIN;
			ST_PIN, ST_I2C:
				if (GLOBAL_ENABLE_N)
					next_st = ST_SAVE;
		endcase
	end

	always_ff @(posedge CLK_SYS)
	begin
		if (!RST_B)
			st <= ST_BOOT;
		else
			st <= next_st;
	end

	assign active      = (st == ST_PIN) || (st == ST_I2C);
	assign stat_change = (stat_q != stat_prev);

	// connection status is sampled only while active, so power saving shows as unattached
	always_ff @(posedge CLK_SYS)
	begin
		if (!RST_B)
		begin
			stat_q    <= '0;
			stat_prev <= '0;
		end
		else
		begin
			stat_q    <= active ? {ATTACHED, ATTACHED & ATTACH_AS_SRC, AUDIO_ACC, ATTACH_CURRENT} : '0;
			stat_prev <= stat_q;
		end
	end

	// pending status: a change in the clearing cycle wins, so no event is lost
	always_ff @(posedge CLK_SYS)
	begin
		if (!RST_B || st != ST_I2C)
			STATUS_PENDING <= 1'b0;
		else if (stat_change)
			STATUS_PENDING <= 1'b1;
		else if (HOST_STATUS_READ)
			STATUS_PENDING <= 1'b0;
	end

	// channel terminations; dual role follows the toggle until attach resolves it
	always_ff @(posedge CLK_SYS)
	begin
		if (!RST_B || st == ST_BOOT)
		begin
			CONFIG_CHANNEL_A_PULLUP <= 1'b0;
			CONFIG_CHANNEL_B_PULLUP <= 1'b0;
		end
		else
		begin
			CONFIG_CHANNEL_A_PULLUP <= active && (strap.role == ROLE_SRC ||
				(strap.role == ROLE_DRP && (stat_q.att ? stat_q.src : DRP_SEEK_SRC)));
			CONFIG_CHANNEL_B_PULLUP <= active && (strap.role == ROLE_SRC ||
				(strap.role == ROLE_DRP && (stat_q.att ? stat_q.src : DRP_SEEK_SRC)));
		end
	end

	// shared current pins: pushed code in pin mode, open-drain bus lines in bus mode
	always_ff @(posedge CLK_SYS)
	begin
		if (!RST_B || !active)
		begin
			{CURRENT_MODE_BIT_HI_O, CURRENT_MODE_BIT_LO_O}   <= 2'h0;
			{CURRENT_MODE_BIT_HI_OE, CURRENT_MODE_BIT_LO_OE} <= 2'h0;
		end
		else if (st == ST_PIN)
		begin
			{CURRENT_MODE_BIT_HI_O, CURRENT_MODE_BIT_LO_O}   <= cur_pins(stat_q.att, stat_q.cur);
			{CURRENT_MODE_BIT_HI_OE, CURRENT_MODE_BIT_LO_OE} <= 2'h3;
		end
		else
		begin
			{CURRENT_MODE_BIT_HI_O, CURRENT_MODE_BIT_LO_O}   <= 2'h0;
			{CURRENT_MODE_BIT_HI_OE, CURRENT_MODE_BIT_LO_OE} <= {I2C_SCL_PULL, I2C_SDA_PULL};
		end
	end

	// bus line levels toward the engine; idle high outside bus mode
	always_ff @(posedge CLK_SYS)
	begin
		if (!RST_B || st != ST_I2C)
		begin
			BUS_SDA <= 1'b1;
			BUS_SCL <= 1'b1;
		end
		else
		begin
			BUS_SDA <= CURRENT_MODE_BIT_LO_I;
			BUS_SCL <= CURRENT_MODE_BIT_HI_I;
		end
	end

	// shared flag pin: accessory level in pin mode, low-pulling interrupt in bus mode
	always_ff @(posedge CLK_SYS)
	begin
		if (!RST_B || !active)
		begin
			IRQ_FLAG_N_O  <= 1'b0;
			IRQ_FLAG_N_OE <= 1'b0;
		end
		else if (st == ST_PIN)
		begin
			IRQ_FLAG_N_O  <= !stat_q.aud;
			IRQ_FLAG_N_OE <= 1'b1;
		end
		else
		begin
			IRQ_FLAG_N_O  <= 1'b0;
			IRQ_FLAG_N_OE <= STATUS_PENDING;
		end
	end

	// source flag is open drain: the level is always low, only the enable moves
	always_ff @(posedge CLK_SYS)
	begin
		if (!RST_B)
		begin
			SOURCE_ROLE_FLAG_N_O  <= 1'b0;
			SOURCE_ROLE_FLAG_N_OE <= 1'b0;
		end
		else
		begin
			SOURCE_ROLE_FLAG_N_O  <= 1'b0;
			SOURCE_ROLE_FLAG_N_OE <= active && stat_q.att && stat_q.src;
		end
	end

	// mode reporting toward the bus engine and the rest of the chip
	always_ff @(posedge CLK_SYS)
	begin
		if (!RST_B)
		begin
			I2C_MODE   <= 1'b0;
			I2C_ADDR   <= `TCC_ADDR_RST;
			POWER_SAVE <= 1'b0;
		end
		else
		begin
			I2C_MODE   <= (st == ST_I2C);
			I2C_ADDR   <= strap.i2c_addr;
			POWER_SAVE <= (st == ST_SAVE);
		end
	end

	// clock phase check; the first phase after entry is partial, so it is not judged
	always_ff @(posedge CLK_SYS)
	begin
		if (!RST_B || st != ST_I2C)
		begin
			scl_prev     <= 1'b1;
			scl_seen     <= 1'b0;
			scl_cnt      <= 6'h00;
			BUS_RATE_ERR <= 1'b0;
		end
		else
		begin
			scl_prev <= BUS_SCL;
			if (BUS_SCL != scl_prev)
			begin
				scl_cnt      <= 6'h00;
				scl_seen     <= 1'b1;
				BUS_RATE_ERR <= scl_seen && (scl_cnt < (scl_prev ? SCL_HIGH_LIM : SCL_LOW_LIM));
			end
			else
			begin
				BUS_RATE_ERR <= 1'b0;
				if (scl_cnt != 6'h3f)
					scl_cnt <= scl_cnt + 6'h01;
			end
		end
	end

	sequence seq_save_held;
		GLOBAL_ENABLE_N [*4];
	endsequence

	sequence seq_status_read;
		STATUS_PENDING && HOST_STATUS_READ && !stat_change && st == ST_I2C;
	endsequence

	chk_boot_sink: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		st == ST_BOOT |=> !CONFIG_CHANNEL_A_PULLUP && !CONFIG_CHANNEL_B_PULLUP)
		else $error("channel pins not in sink termination during boot");

	chk_irq_pull_low: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		st == ST_I2C && STATUS_PENDING |=> IRQ_FLAG_N_OE && !IRQ_FLAG_N_O)
		else $error("pending status not pulling interrupt low");

	chk_audio_level: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		st == ST_PIN |=> IRQ_FLAG_N_OE && IRQ_FLAG_N_O == !$past(stat_q.aud))
		else $error("accessory flag level wrong in pin mode");

	chk_current_code: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		st == ST_PIN |=> {CURRENT_MODE_BIT_HI_O, CURRENT_MODE_BIT_LO_O}
			== cur_pins($past(stat_q.att), $past(stat_q.cur)))
		else $error("current code on shared pins wrong");

	chk_unattached_code: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		st == ST_PIN && !stat_q.att |=> CURRENT_MODE_BIT_HI_O == 1'b0 && CURRENT_MODE_BIT_LO_O == 1'b1)
		else $error("unattached pins do not show no connection");

	chk_source_flag: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		active && stat_q.att && stat_q.src |=> SOURCE_ROLE_FLAG_N_OE && !SOURCE_ROLE_FLAG_N_O)
		else $error("source flag not pulled low while attached as source");

	chk_save_release: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		seq_save_held |-> POWER_SAVE && !CURRENT_MODE_BIT_LO_OE && !CURRENT_MODE_BIT_HI_OE
			&& !IRQ_FLAG_N_OE && !SOURCE_ROLE_FLAG_N_OE)
		else $error("pins still driven in power saving");

	chk_change_pending: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		st == ST_I2C && stat_change |=> STATUS_PENDING ##1 (IRQ_FLAG_N_OE || st != ST_I2C))
		else $error("status change did not raise the interrupt");

	chk_rate_flag: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		st == ST_I2C && scl_seen && BUS_SCL != scl_prev && scl_prev && scl_cnt < SCL_HIGH_LIM
			|=> BUS_RATE_ERR)
		else $error("short clock high phase not flagged");

	chk_irq_release: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		seq_status_read |=> !STATUS_PENDING ##1 !IRQ_FLAG_N_OE)
		else $error("interrupt not released after status read");

endmodule

// file: hw/tcc_consts.svh
// constants of the type-c pin control block: strap codes, addresses, current codes, timing
// assumes nothing; included by the package and by the design modules
`ifndef TCC_CONSTS_SVH
`define TCC_CONSTS_SVH

// sense code of a three-level strap, as delivered by the pad comparators
`define TCC_STRAP_FLOAT     2'h0
`define TCC_STRAP_HIGH      2'h1
`define TCC_STRAP_LOW       2'h2

// 7-bit bus addresses selected by the control strap
`define TCC_ADDR_STRAP_HIGH 7'h68
`define TCC_ADDR_STRAP_LOW  7'h60
`define TCC_ADDR_RST        7'h00

// advertised current of the attached partner, from the attach logic
`define TCC_CUR_DEFAULT     2'h0
`define TCC_CUR_1P5         2'h1
`define TCC_CUR_3P0         2'h2

// pattern on the two shared pins, upper bit first
`define TCC_PINS_DEFAULT    2'h3
`define TCC_PINS_1P5        2'h2
`define TCC_PINS_3P0        2'h0
`define TCC_PINS_NONE       2'h1

// bus clock timing at the system clock rate
`define TCC_CLK_PERIOD_NS   40
`define TCC_SCL_LOW_MIN_NS  1300
`define TCC_SCL_HIGH_MIN_NS 600
`define TCC_SCL_LOW_MIN_CYC  ((`TCC_SCL_LOW_MIN_NS + `TCC_CLK_PERIOD_NS - 1) / `TCC_CLK_PERIOD_NS)
`define TCC_SCL_HIGH_MIN_CYC ((`TCC_SCL_HIGH_MIN_NS + `TCC_CLK_PERIOD_NS - 1) / `TCC_CLK_PERIOD_NS)

`endif

// file: hw/tcc_pkg.sv
// types shared by the type-c pin control modules
// assumes the constants header is reachable by its bare name
package tcc_pkg;
`include "tcc_consts.svh"

	typedef enum logic [1:0] {
		ROLE_SNK = 2'h0,
		ROLE_SRC = 2'h1,
		ROLE_DRP = 2'h2
	} tcc_role_t;

	typedef enum logic [3:0] {
		ST_BOOT = 4'h1,
		ST_SAVE = 4'h2,
		ST_PIN  = 4'h4,
		ST_I2C  = 4'h8
	} tcc_state_t;

	typedef struct packed {
		logic       att;
		logic       src;
		logic       aud;
		logic [1:0] cur;
	} tcc_status_t;
endpackage

// file: hw/tcc_strap_if.sv
// carrier for the strap decisions between the strap latch and the pin controller
// assumes both ends share one clock
`timescale 1ns/1ps
interface tcc_strap_if;
	import tcc_pkg::*;
	tcc_role_t  role;
	logic       i2c_sel;
	logic [6:0] i2c_addr;
	logic       valid;

	modport src (output role, output i2c_sel, output i2c_addr, output valid);
	modport dst (input role, input i2c_sel, input i2c_addr, input valid);
endinterface

// file: hw/tcc_strap_latch.sv
// strap latch: catches the role and control straps once after reset release
// assumes strap sense codes are synchronous to clk_sys and settled at release
`timescale 1ns/1ps
`include "tcc_consts.svh"
module tcc_strap_latch
	import tcc_pkg::*;
(
	input  wire logic       clk_sys,
	input  wire logic       rst_b,
	input  wire logic [1:0] role_strap,
	input  wire logic [1:0] ctrl_strap,
	tcc_strap_if.src        strap
);

	// an unknown sense code falls back to dual role, the most forgiving choice
	function automatic tcc_role_t decode_role(input logic [1:0] code);
		case (code)
			`TCC_STRAP_HIGH: decode_role = ROLE_SRC;
			`TCC_STRAP_LOW:  decode_role = ROLE_SNK;
			default:         decode_role = ROLE_DRP;
		endcase
	endfunction

	function automatic logic [6:0] decode_addr(input logic [1:0] code);
		case (code)
			`TCC_STRAP_HIGH: decode_addr = `TCC_ADDR_STRAP_HIGH;
			`TCC_STRAP_LOW:  decode_addr = `TCC_ADDR_STRAP_LOW;
			default:         decode_addr = `TCC_ADDR_RST;
		endcase
	endfunction

	// caught on the first edge after release, never under reset; later strap moves are ignored
	always_ff @(posedge clk_sys)
	begin
		if (!rst_b)
		begin
			strap.valid    <= 1'b0;
			strap.role     <= ROLE_SNK;
			strap.i2c_sel  <= 1'b0;
			strap.i2c_addr <= `TCC_ADDR_RST;
		end
		else if (!strap.valid)
		begin
			strap.valid    <= 1'b1;
			strap.role     <= decode_role(role_strap);
			strap.i2c_sel  <= (ctrl_strap != `TCC_STRAP_FLOAT);
			strap.i2c_addr <= decode_addr(ctrl_strap);
		end
	end

	chk_role_decode: assert property (@(posedge clk_sys) disable iff (!rst_b)
		$rose(strap.valid) |-> strap.role == decode_role($past(role_strap)))
		else $error("role strap decoded wrongly");

	chk_addr_decode: assert property (@(posedge clk_sys) disable iff (!rst_b)
		$rose(strap.valid) |-> strap.i2c_addr == decode_addr($past(ctrl_strap))
			&& strap.i2c_sel == ($past(ctrl_strap) != `TCC_STRAP_FLOAT))
		else $error("control strap decoded wrongly");

	chk_strap_hold: assert property (@(posedge clk_sys) disable iff (!rst_b)
		strap.valid |=> strap.valid && $stable(strap.role) && $stable(strap.i2c_addr))
		else $error("strap decision moved after capture");

endmodule

// file: dv/tcc_partner.sv
// partner model: host clock generator and pull-ups on the two shared pins
// assumes the bench sets run and the phase lengths from the falling edge of the clock
`timescale 1ns/1ps
module tcc_partner
(
	input  wire logic       clk,
	input  wire logic       run,
	input  wire logic [5:0] hi_len,
	input  wire logic [5:0] lo_len,
	input  wire logic       lo_o,
	input  wire logic       lo_oe,
	input  wire logic       hi_o,
	input  wire logic       hi_oe,
	output logic            lo_i,
	output logic            hi_i
);
	logic       scl_pull = 1'b0;
	logic [5:0] cnt      = 6'h00;

	// host clock stands high outside traffic; short phases only when the bench asks for them
	// stepped on the rising edge so falling-edge updates of run never race with it
	// a stop request lets a low phase run to its full length, so stopping never makes a short phase
	always @(posedge clk)
	begin
		if (!run && !scl_pull)
		begin
			scl_pull <= 1'b0;
			cnt      <= 6'h00;
		end
		else if (cnt + 6'h01 >= (scl_pull ? lo_len : hi_len))
		begin
			scl_pull <= !scl_pull;
			cnt      <= 6'h00;
		end
		else
			cnt <= cnt + 6'h01;
	end

	// pull-ups win when nobody pulls low, so a released pin never keeps its last driven value
	assign lo_i = !(lo_oe && !lo_o);
	assign hi_i = !((hi_oe && !hi_o) || scl_pull);
endmodule

// file: dv/tcc_pin_ctrl_tb.sv
// self-checking bench of the pin controller: straps, status pins, interrupt, bus pins, power saving
// assumes the design package and the partner model are compiled before it
`timescale 1ns/1ps
`include "tcc_consts.svh"
module tcc_pin_ctrl_tb;
	import tcc_pkg::*;
	logic       clk_sys = 1'b0;
	logic       rst_b = 1'b0;
	logic [1:0] role_strap = 2'h0;
	logic [1:0] ctrl_strap = 2'h0;
	logic       global_enable_n = 1'b0;
	logic       attached = 1'b0;
	logic       attach_as_src = 1'b0;
	logic       audio_acc = 1'b0;
	logic [1:0] attach_current = 2'h0;
	logic       drp_seek_src = 1'b1;
	logic       host_status_read = 1'b0;
	logic       sda_pull = 1'b0;
	logic       scl_pull = 1'b0;
	logic       run = 1'b0;
	logic [5:0] hi_len = 6'h14;
	logic [5:0] lo_len = 6'h2b;
	logic       lo_i, hi_i, lo_o, lo_oe, hi_o, hi_oe, irq_o, irq_oe, src_o, src_oe;
	logic       pu_a, pu_b, i2c_mode, bus_sda, bus_scl, rate_err, power_save, status_pending;
	logic [6:0] i2c_addr;
	int         n_mismatch = 0;
	int         tests_run = 0;

	// 25 MHz system clock
	initial
	begin
		forever #20 clk_sys = ~clk_sys;
	end

	tcc_pin_ctrl tcc_pin_ctrl_i (.CLK_SYS(clk_sys), .RST_B(rst_b), .ROLE_STRAP(role_strap),
		.CTRL_STRAP(ctrl_strap), .GLOBAL_ENABLE_N(global_enable_n), .ATTACHED(attached),
		.ATTACH_AS_SRC(attach_as_src), .AUDIO_ACC(audio_acc), .ATTACH_CURRENT(attach_current),
		.DRP_SEEK_SRC(drp_seek_src), .HOST_STATUS_READ(host_status_read), .I2C_SDA_PULL(sda_pull),
		.I2C_SCL_PULL(scl_pull), .CURRENT_MODE_BIT_LO_I(lo_i), .CURRENT_MODE_BIT_HI_I(hi_i),
		.CURRENT_MODE_BIT_LO_O(lo_o), .CURRENT_MODE_BIT_LO_OE(lo_oe), .CURRENT_MODE_BIT_HI_O(hi_o),
		.CURRENT_MODE_BIT_HI_OE(hi_oe), .IRQ_FLAG_N_O(irq_o), .IRQ_FLAG_N_OE(irq_oe),
		.SOURCE_ROLE_FLAG_N_O(src_o), .SOURCE_ROLE_FLAG_N_OE(src_oe),
		.CONFIG_CHANNEL_A_PULLUP(pu_a), .CONFIG_CHANNEL_B_PULLUP(pu_b), .I2C_MODE(i2c_mode),
		.I2C_ADDR(i2c_addr), .BUS_SDA(bus_sda), .BUS_SCL(bus_scl), .BUS_RATE_ERR(rate_err),
		.POWER_SAVE(power_save), .STATUS_PENDING(status_pending));

	tcc_partner tcc_partner_i (.clk(clk_sys), .run(run), .hi_len(hi_len), .lo_len(lo_len),
		.lo_o(lo_o), .lo_oe(lo_oe), .hi_o(hi_o), .hi_oe(hi_oe), .lo_i(lo_i), .hi_i(hi_i));

	task automatic cyc(input int n);
		repeat (n) @(negedge clk_sys);
	endtask

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic summarize();
		$display("checks %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// reset for 5 cycles with given straps; sink termination until the role has settled
	task automatic t_straps(input logic [1:0] role, input logic [1:0] ctrl, input logic [7:0] mode, input logic pu);
		role_strap = role;
		ctrl_strap = ctrl;
		rst_b = 1'b0;
		cyc(5);
		chk(8'({pu_a, pu_b, i2c_mode}), 8'h00);
		rst_b = 1'b1;
		cyc(1);
		chk(8'({pu_a, pu_b}), 8'h00);
		cyc(3);
		chk({i2c_mode, i2c_addr}, mode);
		chk(8'({pu_a, pu_b}), 8'({pu, pu}));
	endtask

	// bus mode: attach raises the interrupt, a host read releases it, data pin follows the engine
	task automatic t_irq();
		attached = 1'b1;
		attach_current = `TCC_CUR_3P0;
		cyc(5);
		chk(8'({status_pending, irq_o, irq_oe}), 8'h05);
		chk(8'({lo_oe, hi_oe}), 8'h00);
		host_status_read = 1'b1;
		cyc(1);
		host_status_read = 1'b0;
		cyc(2);
		chk(8'({status_pending, irq_oe}), 8'h00);
		sda_pull = 1'b1;
		scl_pull = 1'b1;
		cyc(3);
		chk(8'({lo_o, lo_oe, bus_sda}), 8'h02);
		chk(8'({hi_o, hi_oe, bus_scl}), 8'h02);
		sda_pull = 1'b0;
		scl_pull = 1'b0;
		cyc(3);
		chk(8'({lo_oe, bus_sda}), 8'h01);
		chk(8'({hi_oe, bus_scl, rate_err}), 8'h03);
	endtask

	// host clock with given phases; a bounded watch for the rate error pulse
	task automatic t_rate(input logic [5:0] hi, input logic [5:0] lo, input logic exp);
		int seen;
		seen = 0;
		hi_len = hi;
		lo_len = lo;
		run = 1'b1;
		for (int k = 0; k < 300; k++)
		begin
			@(negedge clk_sys);
			if (rate_err === 1'b1)
				seen++;
		end
		run = 1'b0;
		cyc(80);
		chk(8'(seen != 0), 8'(exp));
		if (exp && seen == 0)
			summarize();
	endtask

	// pin mode: every current code, audio flag and source flag, then detach
	task automatic t_pins();
		logic [1:0] cur [3] = '{`TCC_CUR_DEFAULT, `TCC_CUR_1P5, `TCC_CUR_3P0};
		logic [1:0] pat [3] = '{`TCC_PINS_DEFAULT, `TCC_PINS_1P5, `TCC_PINS_3P0};
		for (int k = 0; k < 3; k++)
		begin
			attached = 1'b1;
			attach_current = cur[k];
			audio_acc = k[0];
			attach_as_src = k[0];
			cyc(3);
			chk(8'({hi_o, lo_o, hi_oe, lo_oe}), 8'({pat[k], 2'h3}));
			chk(8'({irq_o, irq_oe}), 8'({!k[0], 1'b1}));
			chk(8'({src_o, src_oe}), 8'({1'b0, k[0]}));
		end
		attached = 1'b0;
		audio_acc = 1'b0;
		attach_as_src = 1'b0;
		cyc(3);
		chk(8'({hi_o, lo_o}), 8'(`TCC_PINS_NONE));
		chk(8'({irq_o, src_oe}), 8'h02);
	endtask

	// power saving releases every driver; active again restores the status pins
	task automatic t_power();
		global_enable_n = 1'b1;
		cyc(4);
		chk(8'({power_save, hi_oe, lo_oe, irq_oe, pu_a}), 8'h10);
		global_enable_n = 1'b0;
		cyc(4);
		chk(8'({power_save, hi_oe, irq_oe}), 8'h03);
	endtask

	// main sequence: bus modes first, then pin mode in dual role
	initial
	begin
		t_straps(`TCC_STRAP_LOW, `TCC_STRAP_HIGH, {1'b1, `TCC_ADDR_STRAP_HIGH}, 1'b0);
		t_straps(`TCC_STRAP_HIGH, `TCC_STRAP_LOW, {1'b1, `TCC_ADDR_STRAP_LOW}, 1'b1);
		t_irq();
		t_rate(6'h14, 6'h2b, 1'b0);
		t_rate(6'h08, 6'h2b, 1'b1);
		attached = 1'b0;
		t_straps(`TCC_STRAP_FLOAT, `TCC_STRAP_FLOAT, {1'b0, `TCC_ADDR_RST}, 1'b1);
		drp_seek_src = 1'b0;
		cyc(3);
		chk(8'({pu_a, pu_b}), 8'h00);
		t_pins();
		t_power();
		summarize();
	end
endmodule
